// file: design/bus_pin_pkg.sv
// Package: constants and carrier types for the primary bus hold and pin control block
package bus_pin_pkg;
  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int FLAG_N = 2;
  localparam logic [23:0] RESET_VECTOR_ADDR = 24'h000000;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Transfer request from the core side
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [31:0] wdata;
  } xfer_req_t;

  // Pin drive bundle of the primary bus
  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] dataOut;
    logic dataOe;
    logic strobeN;
    logic readNotWrite;
    logic busOe;
  } bus_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_HELD = 3'b100
  } bus_state_t;
endpackage : bus_pin_pkg

// file: design/pin_sync.sv
// Module: three-stage synchroniser for an asynchronous pin input
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pinIn,
  output logic pinOut
);
  logic [2:0] stage_r;
  logic out_r;

  // ****************************************************************
  // Sampling chain
  // ****************************************************************
  // Shift the pin through three flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_r <= {3{RESET_VAL}};
    end else begin
      stage_r <= {stage_r[1:0], pinIn};
    end
  end

  // Change accepted once the second and third stages agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_r <= RESET_VAL;
    end else if (stage_r[1] == stage_r[2]) begin
      out_r <= stage_r[2];
    end
  end

  assign pinOut = out_r;
endmodule : pin_sync

// file: design/primary_bus_hold_and_pin_control.sv
// Module: primary bus hold handshake, shutdown float, acknowledge strobe and flag pins
//
// Functional notes
// - On hold request low, finish current transfer then float address, data, strobe, R/W
// - While held, start no transfer; leave hold on request high or hold-ignore set
// - Drive hold grant low for a low hold request; low means bus floating
// - Return hold grant high on request high or hold-ignore bit set
// - Stay reset while reset low; on release fetch from reset vector
// - Shutdown input low halts the device and floats every pin
// - Pulse interrupt acknowledge only when its instruction executes
// - Two flag pins as general I/O or interlock; float during shutdown or reset
`timescale 1ns/1ps
module primary_bus_hold_and_pin_control (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic holdReq_n,
  input wire logic pin_shutdown_n,
  input wire logic readyIn,
  input wire logic hold_ignore_bit,
  input wire bus_pin_pkg::xfer_req_t xferReq,
  output logic xferAccept,
  output logic xferDone,
  output logic [31:0] xferRdata,
  input wire logic [31:0] external_data_lines_in,
  output bus_pin_pkg::bus_pins_t busPins,
  output logic bus_hold_grant_n,
  output logic holdGrantOe,
  input wire logic iackExec,
  output logic irq_ack_strobe,
  output logic irqAckOe,
  input wire logic [1:0] flagOutVal,
  input wire logic [1:0] flagOutEn,
  input wire logic [1:0] extFlagIn,
  output logic [1:0] extFlagSync,
  output logic ext_flag_0,
  output logic ext_flag_1,
  output logic [1:0] extFlagOe,
  output logic [23:0] fetchAddr,
  output logic fetchStart,
  output logic shutdownActive
);
  bus_pin_pkg::bus_state_t state_r;
  bus_pin_pkg::bus_pins_t pins_r;
  logic holdReqSync_n;
  logic shutdownSync_n;
  logic readySync;
  logic [1:0] flagSync;
  logic grant_r;
  logic grantOe_r;
  logic accept_r;
  logic done_r;
  logic [31:0] rdata_r;
  logic irq_ack_strobe_r;
  logic iackOe_r;
  logic [1:0] flagOut_r;
  logic [1:0] flagOe_r;
  logic [1:0] flagIn_r;
  logic [23:0] fetchAddr_r;
  logic fetchStart_r;
  logic fetchPending_r;
  logic shutdown_r;
  logic holdWanted;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pin_sync #(.RESET_VAL(1'b1)) uHoldSync (.clk(clk), .reset_n(reset_n),
    .pinIn(holdReq_n), .pinOut(holdReqSync_n));
  pin_sync #(.RESET_VAL(1'b1)) uShzSync (.clk(clk), .reset_n(reset_n),
    .pinIn(pin_shutdown_n), .pinOut(shutdownSync_n));
  pin_sync #(.RESET_VAL(1'b0)) uRdySync (.clk(clk), .reset_n(reset_n),
    .pinIn(readyIn), .pinOut(readySync));
  pin_sync #(.RESET_VAL(1'b0)) uFlag0Sync (.clk(clk), .reset_n(reset_n),
    .pinIn(extFlagIn[0]), .pinOut(flagSync[0]));
  pin_sync #(.RESET_VAL(1'b0)) uFlag1Sync (.clk(clk), .reset_n(reset_n),
    .pinIn(extFlagIn[1]), .pinOut(flagSync[1]));

  // Hold is wanted while request is low and not overridden
  assign holdWanted = !holdReqSync_n && !hold_ignore_bit;

  // ****************************************************************
  // Shutdown latch
  // ****************************************************************
  // Shutdown sticks until a reset taken with the input high
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shutdown_r <= 1'b0;
    end else if (!shutdownSync_n) begin
      shutdown_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Bus transfer and hold state machine
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n || !shutdownSync_n || shutdown_r) begin
      state_r <= bus_pin_pkg::ST_IDLE;
      pins_r <= '0;
      pins_r.strobeN <= 1'b1;
      pins_r.readNotWrite <= 1'b1;
      accept_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      accept_r <= 1'b0;
      done_r <= 1'b0;
      unique case (state_r)
        bus_pin_pkg::ST_IDLE: begin
          if (holdWanted) begin
            state_r <= bus_pin_pkg::ST_HELD;
            pins_r.busOe <= 1'b0;
            pins_r.dataOe <= 1'b0;
            pins_r.strobeN <= 1'b1;
          end else begin
            pins_r.busOe <= 1'b1;
            // A ready left over from the last transfer must drain first
            if (xferReq.valid && !fetchPending_r && !readySync) begin
              state_r <= bus_pin_pkg::ST_XFER;
              accept_r <= 1'b1;
              pins_r.addr <= xferReq.addr;
              pins_r.dataOut <= xferReq.wdata;
              pins_r.dataOe <= xferReq.write;
              pins_r.readNotWrite <= !xferReq.write;
              pins_r.strobeN <= 1'b0;
            end
          end
        end
        bus_pin_pkg::ST_XFER: begin
          // Transfer ends on ready, even if a hold is waiting
          if (readySync) begin
            state_r <= bus_pin_pkg::ST_IDLE;
            done_r <= 1'b1;
            rdata_r <= external_data_lines_in;
            pins_r.strobeN <= 1'b1;
            pins_r.dataOe <= 1'b0;
            pins_r.readNotWrite <= 1'b1;
          end
        end
        bus_pin_pkg::ST_HELD: begin
          if (!holdWanted) begin
            state_r <= bus_pin_pkg::ST_IDLE;
            pins_r.busOe <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Hold grant output
  // ****************************************************************
  // Grant low only once the bus has floated; registered so glitch-free
  always_ff @(posedge clk) begin
    if (!reset_n || !shutdownSync_n || shutdown_r) begin
      grant_r <= 1'b1;
      grantOe_r <= 1'b0;
    end else begin
      grantOe_r <= 1'b1;
      grant_r <= !(state_r == bus_pin_pkg::ST_HELD && holdWanted);
    end
  end

  // ****************************************************************
  // Reset vector fetch
  // ****************************************************************
  // One fetch request from the reset vector after release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fetchPending_r <= 1'b1;
      fetchStart_r <= 1'b0;
      fetchAddr_r <= bus_pin_pkg::RESET_VECTOR_ADDR;
    end else if (fetchPending_r && !shutdown_r && shutdownSync_n) begin
      fetchStart_r <= 1'b1;
      fetchPending_r <= 1'b0; // Cleared on the same edge, so the pulse is one cycle
    end else begin
      fetchStart_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt acknowledge strobe
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n || !shutdownSync_n || shutdown_r) begin
      irq_ack_strobe_r <= 1'b1;
      iackOe_r <= 1'b0;
    end else begin
      iackOe_r <= 1'b1;
      irq_ack_strobe_r <= !iackExec;
    end
  end

  // ****************************************************************
  // External flag pins
  // ****************************************************************
  // Flags float while reset or shutdown is active
  always_ff @(posedge clk) begin
    if (!reset_n || !shutdownSync_n || shutdown_r) begin
      flagOut_r <= 2'h0;
      flagOe_r <= 2'h0;
      flagIn_r <= 2'h0;
    end else begin
      flagOut_r <= flagOutVal;
      flagOe_r <= flagOutEn;
      flagIn_r <= flagSync;
    end
  end

  // Shutdown flag reported to the core
  logic shutdownOut_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shutdownOut_r <= 1'b0;
    end else begin
      shutdownOut_r <= shutdown_r || !shutdownSync_n;
    end
  end

  assign busPins = pins_r;
  assign xferAccept = accept_r;
  assign xferDone = done_r;
  assign xferRdata = rdata_r;
  assign bus_hold_grant_n = grant_r;
  assign holdGrantOe = grantOe_r;
  assign irq_ack_strobe = irq_ack_strobe_r;
  assign irqAckOe = iackOe_r;
  assign extFlagSync = flagIn_r;
  assign ext_flag_0 = flagOut_r[0];
  assign ext_flag_1 = flagOut_r[1];
  assign extFlagOe = flagOe_r;
  assign fetchAddr = fetchAddr_r;
  assign fetchStart = fetchStart_r;
  assign shutdownActive = shutdownOut_r;
endmodule : primary_bus_hold_and_pin_control

// file: tb/bus_master_model.sv
// Far-side bus master model: hold request, ready and read data
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk,
  input wire logic wantHold,
  input wire logic [2:0] lag,
  input wire bus_pin_pkg::bus_pins_t busPins,
  output logic holdReq_n,
  output logic readyIn,
  output logic [31:0] external_data_lines_in
);
  int waitCnt = 0;
  initial begin
    holdReq_n = 1'b1;
    readyIn = 1'b0;
    external_data_lines_in = 32'h0;
  end
  // Ready rises lag cycles into the strobe; a released bus toggles
  always @(negedge clk) begin
    holdReq_n <= !wantHold;
    waitCnt <= busPins.strobeN ? 0 : waitCnt + 1;
    readyIn <= !busPins.strobeN && waitCnt >= lag;
    if (!busPins.strobeN && busPins.readNotWrite) begin
      external_data_lines_in <= {8'h5A, busPins.addr};
    end else begin
      external_data_lines_in <= ~external_data_lines_in;
    end
  end
endmodule : bus_master_model

// file: tb/bus_pin_ctl_sva.sv
// Checker: hold, transfer, acknowledge and shutdown pin behaviour
`timescale 1ns/1ps
module bus_pin_ctl_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hold_ignore_bit,
  input wire logic iackExec,
  input wire logic xferAccept,
  input wire bus_pin_pkg::bus_pins_t busPins,
  input wire logic bus_hold_grant_n,
  input wire logic holdGrantOe,
  input wire logic irq_ack_strobe,
  input wire logic irqAckOe,
  input wire logic [1:0] extFlagOe,
  input wire logic [23:0] fetchAddr,
  input wire logic fetchStart
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Pin relations
  a_grant_floats:
    assert property (!bus_hold_grant_n |-> !busPins.busOe && !busPins.dataOe)
    else $error("grant low with bus driven");
  a_strobe_driven:
    assert property (!busPins.strobeN |-> busPins.busOe && bus_hold_grant_n)
    else $error("strobe low on floated bus");
  a_held_no_start:
    assert property (!bus_hold_grant_n |-> !xferAccept) else $error("accept while held");
  a_ignore_release:
    assert property (hold_ignore_bit |=> bus_hold_grant_n) else $error("grant kept low");
  a_grant_after_float:
    assert property ($fell(bus_hold_grant_n) |-> !$past(busPins.busOe) && !busPins.busOe)
    else $error("grant before float");
  a_irq_ack_strobe_cause:
    assert property (!irq_ack_strobe |-> $past(iackExec) && irqAckOe)
    else $error("stray acknowledge");
  a_fetch_pulse:
    assert property (fetchStart |-> fetchAddr == bus_pin_pkg::RESET_VECTOR_ADDR ##1 !fetchStart)
    else $error("bad reset fetch");
  a_irq_ack_strobe_follows:
    assert property (iackExec && irqAckOe |=> !irq_ack_strobe) else $error("no acknowledge");
  a_float_together:
    assert property (!holdGrantOe |-> !busPins.busOe && extFlagOe == 2'h0 && !irqAckOe)
    else $error("pin left driven");
endmodule : bus_pin_ctl_sva

bind primary_bus_hold_and_pin_control bus_pin_ctl_sva chk (.clk, .reset_n, .hold_ignore_bit,
  .iackExec, .xferAccept, .busPins, .bus_hold_grant_n, .holdGrantOe, .irq_ack_strobe,
  .irqAckOe, .extFlagOe, .fetchAddr, .fetchStart);

// file: tb/tb_primary_bus_hold_and_pin_control.sv
// Testbench for the primary bus hold and pin control block
`timescale 1ns/1ps
module tb_primary_bus_hold_and_pin_control;
  logic clk = 0, reset_n = 0, pin_shutdown_n = 1, hold_ignore_bit = 0, iackExec = 0;
  logic wantHold = 0, holdReq_n, readyIn, xferAccept, xferDone, bus_hold_grant_n;
  logic holdGrantOe, irq_ack_strobe, irqAckOe, ext_flag_0, ext_flag_1, fetchStart;
  logic shutdownActive;
  logic [2:0] lag = 0;
  logic [1:0] flagOutVal = 0, flagOutEn = 0, extFlagIn = 0, extFlagSync, extFlagOe;
  logic [31:0] xferRdata, external_data_lines_in, seed = 32'h12;
  logic [23:0] fetchAddr;
  bus_pin_pkg::xfer_req_t xferReq = '0;
  bus_pin_pkg::bus_pins_t busPins;
  int miscompares = 0, total_checks = 0;
  always #5 clk = ~clk;
  primary_bus_hold_and_pin_control uut (.clk, .reset_n, .holdReq_n, .pin_shutdown_n,
    .readyIn, .hold_ignore_bit, .xferReq, .xferAccept, .xferDone, .xferRdata,
    .external_data_lines_in, .busPins, .bus_hold_grant_n, .holdGrantOe, .iackExec,
    .irq_ack_strobe, .irqAckOe, .flagOutVal, .flagOutEn, .extFlagIn, .extFlagSync,
    .ext_flag_0, .ext_flag_1, .extFlagOe, .fetchAddr, .fetchStart, .shutdownActive);
  bus_master_model far (.clk, .wantHold, .lag, .busPins, .holdReq_n, .readyIn,
    .external_data_lines_in);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic waitOn(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(32'(s === v), 32'h1);
  endtask : waitOn
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task doReset;
    reset_n = 0;
    cyc(3);
    chk({busPins.busOe, busPins.dataOe, extFlagOe, holdGrantOe}, 32'h0);
    cyc(3);
    reset_n = 1;
    cyc(1);
    chk(32'(fetchStart), 32'h1);
    chk(32'(fetchAddr), 32'(bus_pin_pkg::RESET_VECTOR_ADDR));
  endtask : doReset
  // Whole transfer; read data must come from the far side
  task xfer(input logic w, input logic [23:0] a, input logic [31:0] d);
    cyc(5);
    xferReq = '{1'b1, w, a, d};
    waitOn(xferAccept, 1'b1);
    chk({busPins.readNotWrite, busPins.addr}, {!w, a});
    chk(32'({busPins.strobeN, busPins.dataOe}), 32'({1'b0, w}));
    if (w) chk(busPins.dataOut, d);
    xferReq.valid = 1'b0;
    waitOn(xferDone, 1'b1);
    if (!w) chk(xferRdata, {8'h5A, a});
  endtask : xfer
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    doReset();
    repeat (6) begin
      lag = 3'(rnd());
      xfer(1'(rnd()), 24'(rnd()), rnd());
    end
    $display("test transfers done");
    lag = 3'h5;
    fork
      xfer(1'b0, 24'hFFFFFF, 32'h0);
      begin cyc(7); wantHold = 1; end
    join
    waitOn(bus_hold_grant_n, 1'b0);
    chk({busPins.busOe, busPins.dataOe, holdGrantOe}, 32'h1);
    xferReq = '{1'b1, 1'b1, 24'h000001, 32'hFFFFFFFF};
    cyc(10);
    chk({bus_hold_grant_n, busPins.strobeN}, 32'h1);
    hold_ignore_bit = 1;
    cyc(1);
    chk(32'(bus_hold_grant_n), 32'h1);
    waitOn(xferAccept, 1'b1);
    xferReq.valid = 1'b0;
    waitOn(xferDone, 1'b1);
    wantHold = 0;
    cyc(6);
    hold_ignore_bit = 0;
    cyc(2);
    chk({bus_hold_grant_n, busPins.busOe}, 32'h3);
    $display("test hold done");
    repeat (4) begin
      cyc(int'(rnd() % 3) + 1);
      iackExec = 1;
      cyc(1);
      iackExec = 0;
      chk({irq_ack_strobe, irqAckOe}, 32'h1);
      cyc(1);
      chk(32'(irq_ack_strobe), 32'h1);
    end
    repeat (4) begin
      {flagOutVal, flagOutEn, extFlagIn} = 6'(rnd());
      cyc(5);
      chk({ext_flag_1, ext_flag_0} & flagOutEn, flagOutVal & flagOutEn);
      chk({extFlagOe, extFlagSync}, {flagOutEn, extFlagIn});
    end
    $display("test irq_ack_strobe and flags done");
    pin_shutdown_n = 0;
    cyc(6);
    chk({shutdownActive, busPins.busOe, extFlagOe, holdGrantOe, irqAckOe}, 32'h20);
    pin_shutdown_n = 1;
    cyc(3);
    chk(32'(shutdownActive), 32'h1);
    doReset();
    chk(32'(shutdownActive), 32'h0);
    xfer(1'b0, 24'h123456, 32'h0);
    $display("test shutdown done");
    print_verdict();
  end
endmodule : tb_primary_bus_hold_and_pin_control
